// file: cpu_clk_divider.sv
// CPU clock enable divider: one pulse per 1, 2, 4, 8 or 16 cycles.
// Assumes one clock; run low freezes the count.
`timescale 1ns/10ps
`include "pmc_cfg.svh"

module cpu_clk_divider (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Control
	input  wire logic       run,
	input  wire logic       div8,
	input  wire logic [1:0] field,
	// Enable out
	output logic            pulse
);

	logic [3:0] count_reg;
	logic [3:0] mask;

	// ----------------------------------------
	// Ratio decode
	// ----------------------------------------
	function automatic logic [3:0] div_mask(input logic d8,
		input logic [1:0] f);
		if (d8) begin
			return `PMC_MASK_8;
		end
		unique case (f)
			`PMC_DIV_1:  return `PMC_MASK_1;
			`PMC_DIV_2:  return `PMC_MASK_2;
			`PMC_DIV_4:  return `PMC_MASK_4;
			`PMC_DIV_16: return `PMC_MASK_16;
		endcase
	endfunction

	assign mask  = div_mask(div8, field);
	assign pulse = run && ((count_reg & mask) == mask);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= 4'h0;
		end else if (run) begin
			count_reg <= count_reg + 4'h1;
		end
	end

endmodule

// file: irq_source_model.sv
// Interrupt sources facing the controller: raises a chosen request set.
// Assumes bench controls change at falling edges by nonblocking writes.
`timescale 1ns/10ps

module irq_source_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Bench control
	input  wire logic       arm,
	input  wire logic [6:0] pick,
	input  wire logic [3:0] lag,
	// Controller side
	input  wire logic       wake_ack,
	output logic      [6:0] irq
);
	logic [4:0] cnt_reg;
	logic       acked_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			acked_reg <= 1'b0;
		else
			acked_reg <= (|irq) && wake_ack;
	end

	// Only priority-enabled sources, raised after setup
	always_ff @(negedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 5'h00;
			irq     <= 7'h00;
		end else if (arm) begin
			cnt_reg <= {1'b1, lag};
			irq     <= 7'h00;
		end else if (cnt_reg == 5'h10) begin
			cnt_reg <= 5'h00;
			irq     <= pick;
		end else if (cnt_reg != 5'h00) begin
			cnt_reg <= cnt_reg - 5'h01;
		end else if (acked_reg) begin
			irq <= 7'h00;
		end
	end
endmodule

// file: pmc_cfg.svh
// Constants of the power-mode clock controller.
// Assumes inclusion by bare name from cpu_clk_divider and power_mode_clock_control.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// ----------------------------------------
// CPU divider field codes
// ----------------------------------------
`define PMC_DIV_1         2'h0
`define PMC_DIV_2         2'h1
`define PMC_DIV_4         2'h2
`define PMC_DIV_16        2'h3
`define PMC_MASK_1        4'h0
`define PMC_MASK_2        4'h1
`define PMC_MASK_4        4'h3
`define PMC_MASK_8        4'h7
`define PMC_MASK_16       4'hf

// ----------------------------------------
// Clock output selection codes
// ----------------------------------------
`define PMC_CKO_PORT      2'h0
`define PMC_CKO_SUB       2'h1
`define PMC_CKO_F8        2'h2
`define PMC_CKO_F32       2'h3

// ----------------------------------------
// Prescaler taps and reset values
// ----------------------------------------
`define PMC_F8_BIT        2
`define PMC_F32_BIT       4
`define PMC_DIV8_RST      1'h1
`define PMC_DRIVE_RST     1'h1

`endif

// file: pmc_pkg.sv
// Types shared by the power-mode clock controller files.
// Assumes nothing of its surroundings.
package pmc_pkg;

	// ----------------------------------------
	// Decoded operating mode
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_PLL,
		MODE_HIGH,
		MODE_MEDIUM,
		MODE_LOW,
		MODE_LOW_POWER,
		MODE_ONCHIP,
		MODE_ONCHIP_LP,
		MODE_ILLEGAL
	} mode_type;

	// ----------------------------------------
	// Power state
	// ----------------------------------------
	typedef enum logic [1:0] {
		PS_RUN,
		PS_WAIT,
		PS_STOP
	} power_type;

endpackage

// file: power_mode_clock_control.sv
// Power-mode clock controller: mode decode, CPU and peripheral clock
// enables, wait and stop handling, sleep pin states.
// Assumes the CPU, interrupt sources and bus logic share CLOCK; the sub
// clock level arrives from a pin and is synchronised here.
//
// Behaviour
// [RL1] Mode decoded from clock selection bits
// [RL2] CPU divide 1,2,4,16 by field; 8 forced
// [RL3] Main off in low-speed forces divide-by-8
// [RL4] Wait gates CPU; watchdog may use ring
// [RL5] Oscillators keep running during wait
// [RL6] Gate bit stops peripheral clocks in wait
// [RL7] Wait entered only by wait instruction
// [RL8] Software leaves PLL selection before wait
// [RL9] Wait holds bus lines, strobes high
// [RL10] Wait clock output per selection and gate
// [RL11] Wait ends on reset, NMI, LVD, peripheral
// [RL12] Software zeroes priorities for non-peripheral wake
// [RL13] Gate bit limits wake to external clocks
// [RL14] Converter and timer wake conditions
// [RL15] Software orders priorities, I flag, start
// [RL16] Interrupt starts once CPU clock returns
// [RL17] Wait wake keeps source and divider
// [RL18] Stop halts every oscillator and clock
// [RL19] Stop exit sources and their conditions
// [RL20] Stop write forces divide-8, drive high
// [RL21] Software clears fail detect before stop
// [RL22] Software leaves PLL before stop
// [RL23] Stop pin states for bus, clock out
// [RL24] Stop wake: sub clock or source/8
// [RL25] Decoded current mode is exposed
`timescale 1ns/10ps
`include "pmc_cfg.svh"

module power_mode_clock_control (
	// Clock and reset
	input  wire logic             CLOCK,
	input  wire logic             RST_B,
	// Configuration write
	input  wire logic             CFG_WR,
	input  wire logic             OSC_SOURCE_SEL,
	input  wire logic             PLL_CPU_SEL,
	input  wire logic [1:0]       CPU_DIV_FIELD,
	input  wire logic             SUBCLK_CPU_SEL,
	input  wire logic             DIV8_WR,
	input  wire logic             MAINOSC_OFF,
	input  wire logic             SUBOSC_ON,
	input  wire logic             PERIPH_CLK_GATE_WAIT,
	input  wire logic             MAINOSC_DRIVE_WR,
	input  wire logic             WDT_RING_SRC,
	input  wire logic [1:0]       CLOCK_OUT_PIN_SEL,
	// CPU events
	input  wire logic             ALL_CLK_STOP_WR,
	input  wire logic             WAIT_EXEC,
	// Wake sources
	input  wire logic             NMI_IRQ,
	input  wire logic             LVD_IRQ,
	input  wire logic             KEY_IRQ,
	input  wire logic             PIN_IRQ,
	input  wire logic             SER_IRQ,
	input  wire logic             SER_EXT_CLK,
	input  wire logic             TMR_IRQ,
	input  wire logic             TMR_EVENT_MODE,
	input  wire logic             TMR_SUB_SRC,
	input  wire logic             TMR_EXT_PULSE,
	input  wire logic             CONV_IRQ,
	input  wire logic             CONV_SINGLE,
	// Sub clock pin
	input  wire logic             SUB_CLK_PIN,
	// Bus side from CPU
	input  wire logic             BUS_ACTIVE,
	input  wire logic [19:0]      ADDR_IN,
	input  wire logic [15:0]      DATA_IN,
	input  wire logic [3:0]       CS_B_IN,
	input  wire logic             BYTE_HIGH_IN,
	input  wire logic             READ_B_IN,
	input  wire logic             WRITE_LOW_IN,
	input  wire logic             WRITE_HIGH_IN,
	input  wire logic             HOLD_ACK_IN,
	input  wire logic             BUS_CLK_IN,
	input  wire logic             ALE_IN,
	// Mode and status
	output pmc_pkg::mode_type     MODE,
	output pmc_pkg::power_type    POWER_STATE,
	output logic                  DIV8_FORCE,
	output logic                  MAINOSC_DRIVE_HIGH,
	output logic                  WAKE_ACK,
	// Clock enables and oscillator controls
	output logic                  CPU_CLK_EN,
	output logic                  WDT_CLK_EN,
	output logic                  PERIPH_CLK_EN,
	output logic                  CONVERTER_CLK_EN,
	output logic                  SUB_DIV32_CLK_EN,
	output logic                  MAIN_OSC_RUN,
	output logic                  SUB_OSC_RUN,
	output logic                  RING_OSC_RUN,
	// Pins
	output logic [19:0]           ADDR_OUT,
	output logic [15:0]           DATA_OUT,
	output logic [3:0]            CS_B_OUT,
	output logic                  BYTE_HIGH_OUT,
	output logic                  READ_B_OUT,
	output logic                  WRITE_LOW_OUT,
	output logic                  WRITE_HIGH_OUT,
	output logic                  HOLD_ACK_OUT,
	output logic                  BUS_CLK_OUT,
	output logic                  ALE_OUT,
	output logic                  CLOCK_OUT_PIN
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic                 osc_source_sel_reg;
	logic                 pll_cpu_sel_reg;
	logic [1:0]           cpu_div_field_reg;
	logic                 subclk_cpu_sel_reg;
	logic                 div8_force_reg;
	logic                 mainosc_off_reg;
	logic                 subosc_on_reg;
	logic                 gate_reg;
	logic                 drive_high_reg;
	pmc_pkg::power_type   state_reg;
	pmc_pkg::mode_type    mode;
	logic [2:0]           sub_sync_reg;
	logic                 sub_rise;
	logic                 in_run;
	logic                 in_wait;
	logic                 in_stop;
	logic                 wake;
	logic                 div_pulse;
	logic                 periph_run;
	logic [4:0]           presc_reg;
	logic                 cko_reg;
	logic [19:0]          addr_reg;
	logic [15:0]          data_reg;
	logic [3:0]           cs_reg;
	logic                 bhe_reg;

	assign in_run  = (state_reg == pmc_pkg::PS_RUN);
	assign in_wait = (state_reg == pmc_pkg::PS_WAIT);
	assign in_stop = (state_reg == pmc_pkg::PS_STOP);

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	always_comb begin
		mode = pmc_pkg::MODE_ILLEGAL;
		if (subclk_cpu_sel_reg && subosc_on_reg && !pll_cpu_sel_reg) begin
			mode = mainosc_off_reg ? pmc_pkg::MODE_LOW_POWER
				: pmc_pkg::MODE_LOW;                            // [RL1]
		end else if (!subclk_cpu_sel_reg && osc_source_sel_reg
			&& !pll_cpu_sel_reg) begin
			mode = mainosc_off_reg ? pmc_pkg::MODE_ONCHIP_LP
				: pmc_pkg::MODE_ONCHIP;                         // [RL1]
		end else if (!subclk_cpu_sel_reg && !mainosc_off_reg) begin
			if (pll_cpu_sel_reg) begin
				mode = pmc_pkg::MODE_PLL;                       // [RL1]
			end else if (!div8_force_reg
				&& cpu_div_field_reg == `PMC_DIV_1) begin
				mode = pmc_pkg::MODE_HIGH;                      // [RL1]
			end else begin
				mode = pmc_pkg::MODE_MEDIUM;                    // [RL1]
			end
		end
	end

	assign MODE = mode;                                         // [RL25]

	// ----------------------------------------
	// Selection bits
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			osc_source_sel_reg <= 1'h0;
			pll_cpu_sel_reg    <= 1'h0;
			cpu_div_field_reg  <= `PMC_DIV_1;
			subclk_cpu_sel_reg <= 1'h0;
			mainosc_off_reg    <= 1'h0;
			subosc_on_reg      <= 1'h0;
			gate_reg           <= 1'h0;
		end else if (CFG_WR && in_run) begin
			osc_source_sel_reg <= OSC_SOURCE_SEL;
			pll_cpu_sel_reg    <= PLL_CPU_SEL;
			cpu_div_field_reg  <= CPU_DIV_FIELD;
			subclk_cpu_sel_reg <= SUBCLK_CPU_SEL;
			mainosc_off_reg    <= MAINOSC_OFF;
			subosc_on_reg      <= SUBOSC_ON;
			gate_reg           <= PERIPH_CLK_GATE_WAIT;
		end
	end

	// Forced bits: hardware set wins over a software write
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			div8_force_reg <= `PMC_DIV8_RST;
		end else if (in_run && ALL_CLK_STOP_WR) begin
			div8_force_reg <= 1'h1;                      // [RL20] [RL24]
		end else if (CFG_WR && in_run && MAINOSC_OFF
			&& mode == pmc_pkg::MODE_LOW) begin
			div8_force_reg <= 1'h1;                             // [RL3]
		end else if (CFG_WR && in_run
			&& mode != pmc_pkg::MODE_LOW_POWER) begin
			div8_force_reg <= DIV8_WR;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			drive_high_reg <= `PMC_DRIVE_RST;
		end else if (in_run && ALL_CLK_STOP_WR) begin
			drive_high_reg <= 1'h1;                             // [RL20]
		end else if (CFG_WR && in_run) begin
			drive_high_reg <= MAINOSC_DRIVE_WR;
		end
	end

	assign DIV8_FORCE         = div8_force_reg;
	assign MAINOSC_DRIVE_HIGH = drive_high_reg;

	// ----------------------------------------
	// Power state
	// ----------------------------------------
	wake_qualify u_wake (
		.in_wait        (in_wait),
		.in_stop        (in_stop),
		.gate_wait      (gate_reg),
		.nmi_irq        (NMI_IRQ),
		.lvd_irq        (LVD_IRQ),
		.key_irq        (KEY_IRQ),
		.pin_irq        (PIN_IRQ),
		.ser_irq        (SER_IRQ),
		.ser_ext_clk    (SER_EXT_CLK),
		.tmr_irq        (TMR_IRQ),
		.tmr_event_mode (TMR_EVENT_MODE),
		.tmr_sub_src    (TMR_SUB_SRC),
		.tmr_ext_pulse  (TMR_EXT_PULSE),
		.conv_irq       (CONV_IRQ),
		.conv_single    (CONV_SINGLE),
		.wake           (wake)
	);

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= pmc_pkg::PS_RUN;
		end else begin
			unique case (state_reg)
				pmc_pkg::PS_RUN: begin
					if (ALL_CLK_STOP_WR) begin
						state_reg <= pmc_pkg::PS_STOP;          // [RL20]
					end else if (WAIT_EXEC) begin
						state_reg <= pmc_pkg::PS_WAIT;          // [RL7]
					end
				end
				pmc_pkg::PS_WAIT, pmc_pkg::PS_STOP: begin
					if (wake) begin
						state_reg <= pmc_pkg::PS_RUN;           // [RL11]
					end
				end
				default: state_reg <= pmc_pkg::PS_RUN;
			endcase
		end
	end

	assign POWER_STATE = state_reg;
	assign WAKE_ACK    = wake;                                  // [RL16]

	// ----------------------------------------
	// Sub clock sync and CPU clock
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			sub_sync_reg <= 3'h0;
		end else begin
			sub_sync_reg <= {sub_sync_reg[1:0], SUB_CLK_PIN};
		end
	end

	assign sub_rise = sub_sync_reg[1] && !sub_sync_reg[2] && subosc_on_reg;

	cpu_clk_divider u_div (
		.clk   (CLOCK),
		.rst_b (RST_B),
		.run   (in_run),                                        // [RL4]
		.div8  (div8_force_reg),                                // [RL2]
		.field (cpu_div_field_reg),                             // [RL2]
		.pulse (div_pulse)
	);

	// Source and divider untouched in sleep, so wake resumes them
	assign CPU_CLK_EN = in_run
		&& (subclk_cpu_sel_reg ? sub_rise : div_pulse);         // [RL17]
	assign WDT_CLK_EN = in_run ? CPU_CLK_EN
		: (in_wait && WDT_RING_SRC);                            // [RL4]

	// ----------------------------------------
	// Oscillators and peripheral clocks
	// ----------------------------------------
	assign MAIN_OSC_RUN = !mainosc_off_reg && !in_stop;         // [RL5]
	assign SUB_OSC_RUN  = subosc_on_reg && !in_stop;            // [RL18]
	assign RING_OSC_RUN = (osc_source_sel_reg || WDT_RING_SRC)
		&& !in_stop;                                            // [RL5]

	assign periph_run = !in_stop && !(in_wait && gate_reg)
		&& mode != pmc_pkg::MODE_LOW_POWER
		&& mode != pmc_pkg::MODE_ONCHIP_LP;                     // [RL6]
	assign PERIPH_CLK_EN    = periph_run;                       // [RL6]
	assign CONVERTER_CLK_EN = periph_run;                       // [RL6]
	assign SUB_DIV32_CLK_EN = sub_rise && !in_stop;             // [RL18]

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			presc_reg <= 5'h00;
		end else if (periph_run) begin
			presc_reg <= presc_reg + 5'h01;
		end
	end

	// ----------------------------------------
	// Clock output pin
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			cko_reg <= 1'h0;
		end else if (BUS_ACTIVE) begin
			cko_reg <= 1'h0;
		end else if (!CLOCK_OUT_PIN_SEL[1] || periph_run) begin
			// Prescaler taps keep their last level while frozen
			unique case (CLOCK_OUT_PIN_SEL)
				`PMC_CKO_PORT: cko_reg <= 1'h0;
				`PMC_CKO_SUB:  cko_reg <= in_stop ? 1'h1
					: sub_sync_reg[1];                          // [RL10]
				`PMC_CKO_F8:   cko_reg <= presc_reg[`PMC_F8_BIT];  // [RL23]
				`PMC_CKO_F32:  cko_reg <= presc_reg[`PMC_F32_BIT]; // [RL10]
			endcase
		end
	end

	assign CLOCK_OUT_PIN = cko_reg;

	// ----------------------------------------
	// Bus pins during sleep
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			addr_reg <= 20'h00000;
			data_reg <= 16'h0000;
			cs_reg   <= 4'hf;
			bhe_reg  <= 1'h1;
		end else if (in_run) begin
			addr_reg <= ADDR_IN;
			data_reg <= DATA_IN;
			cs_reg   <= CS_B_IN;
			bhe_reg  <= BYTE_HIGH_IN;
		end
	end

	assign ADDR_OUT       = addr_reg;                           // [RL9]
	assign DATA_OUT       = data_reg;
	assign CS_B_OUT       = cs_reg;
	assign BYTE_HIGH_OUT  = bhe_reg;
	assign READ_B_OUT     = in_run ? READ_B_IN : 1'h1;          // [RL9]
	assign WRITE_LOW_OUT  = in_run ? WRITE_LOW_IN : 1'h1;       // [RL23]
	assign WRITE_HIGH_OUT = in_run ? WRITE_HIGH_IN : 1'h1;
	assign HOLD_ACK_OUT   = in_run ? HOLD_ACK_IN : 1'h1;
	assign BUS_CLK_OUT    = in_run ? BUS_CLK_IN : 1'h1;
	assign ALE_OUT        = in_run && ALE_IN;                   // [RL9]

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	stop_forces_bits_a: assert property (              // [RL20]
		in_run && ALL_CLK_STOP_WR |=> in_stop && DIV8_FORCE
			&& MAINOSC_DRIVE_HIGH)
		else $error("stop entry did not force bits");
	lowpower_div8_a: assert property (                 // [RL3]
		in_run && CFG_WR && MAINOSC_OFF && mode == pmc_pkg::MODE_LOW
			&& !ALL_CLK_STOP_WR && SUBCLK_CPU_SEL && SUBOSC_ON
			&& !PLL_CPU_SEL
			|=> DIV8_FORCE && MODE == pmc_pkg::MODE_LOW_POWER)
		else $error("low power entry missed divide-by-8");
	wait_entry_a: assert property (                    // [RL7]
		in_run && !in_wait ##1 in_wait |-> $past(WAIT_EXEC))
		else $error("wait entered without instruction");
	cpu_gated_a: assert property (                     // [RL4]
		!in_run |-> !CPU_CLK_EN)
		else $error("cpu clock active in sleep");
	wdt_ring_a: assert property (                      // [RL4]
		in_wait && WDT_RING_SRC |-> WDT_CLK_EN)
		else $error("watchdog ring count stopped in wait");
	periph_gate_a: assert property (                   // [RL6]
		in_wait && gate_reg |-> !PERIPH_CLK_EN && !CONVERTER_CLK_EN)
		else $error("peripheral clock running in gated wait");
	stop_osc_a: assert property (                      // [RL18]
		in_stop |-> !MAIN_OSC_RUN && !SUB_OSC_RUN && !RING_OSC_RUN)
		else $error("oscillator running in stop");
	wait_osc_a: assert property (                      // [RL5]
		in_wait && !mainosc_off_reg |-> MAIN_OSC_RUN)
		else $error("main oscillator stopped in wait");
	bus_hold_a: assert property (                      // [RL9]
		!in_run ##1 !in_run |-> $stable(ADDR_OUT) && READ_B_OUT
			&& HOLD_ACK_OUT && !ALE_OUT)
		else $error("bus pins not held in sleep");
	wake_keeps_sel_a: assert property (                // [RL17]
		in_wait && wake |=> in_run && $stable(cpu_div_field_reg)
			&& $stable(subclk_cpu_sel_reg))
		else $error("wait wake changed clock selection");
	stop_wake_div8_a: assert property (                // [RL24]
		in_stop && wake |=> in_run && DIV8_FORCE)
		else $error("stop wake not divided by 8");
	stop_f8_hold_a: assert property (                  // [RL23]
		in_stop && !BUS_ACTIVE && CLOCK_OUT_PIN_SEL == `PMC_CKO_F8 ##1 in_stop
			&& !BUS_ACTIVE && CLOCK_OUT_PIN_SEL == `PMC_CKO_F8
			|-> $stable(CLOCK_OUT_PIN))
		else $error("clock output moved in stop");

	wait_wake_c: cover property (in_wait ##1 in_run);
	stop_wake_c: cover property (in_stop ##[1:20] in_run);
	lowpower_c: cover property (MODE == pmc_pkg::MODE_LOW_POWER);

endmodule

// file: tb.sv
// Self-checking bench for the power-mode clock controller.
// Assumes the design files and irq_source_model are compiled first.
`timescale 1ns/10ps

module tb;
	logic               clk, rst_b, cfg_wr, stop_wr, wait_ex, wdt, bus_act;
	logic               sub_pin, arm, div8, drv, wack, cpu_en, wdt_en;
	logic               per_en, cnv_en, mrun, srun, rrun, cko_pin;
	logic [9:0]         cf, v;
	logic [4:0]         qv;
	logic [1:0]         cko;
	logic [5:0]         si;
	logic [3:0]         lag;
	logic [6:0]         pick;
	logic [40:0]        bi;
	logic [31:0]        r, seed;
	pmc_pkg::mode_type  mode, em;
	pmc_pkg::power_type ps;
	wire  [40:0]        ho;
	wire  [5:0]         so;
	wire  [6:0]         irq;
	wire                s32;
	int                 failures, n_checks, i, p;

	power_mode_clock_control u_power_mode_clock_control (
		.CLOCK(clk), .RST_B(rst_b), .CFG_WR(cfg_wr),
		.OSC_SOURCE_SEL(cf[0]), .PLL_CPU_SEL(cf[1]),
		.CPU_DIV_FIELD(cf[3:2]), .SUBCLK_CPU_SEL(cf[4]), .DIV8_WR(cf[5]),
		.MAINOSC_OFF(cf[6]), .SUBOSC_ON(cf[7]),
		.PERIPH_CLK_GATE_WAIT(cf[8]), .MAINOSC_DRIVE_WR(cf[9]),
		.WDT_RING_SRC(wdt), .CLOCK_OUT_PIN_SEL(cko), .ALL_CLK_STOP_WR(stop_wr),
		.WAIT_EXEC(wait_ex), .NMI_IRQ(irq[0]), .LVD_IRQ(irq[1]),
		.KEY_IRQ(irq[2]), .PIN_IRQ(irq[3]), .SER_IRQ(irq[4]),
		.SER_EXT_CLK(qv[0]), .TMR_IRQ(irq[5]), .TMR_EVENT_MODE(qv[1]),
		.TMR_SUB_SRC(qv[2]), .TMR_EXT_PULSE(qv[3]), .CONV_IRQ(irq[6]),
		.CONV_SINGLE(qv[4]), .SUB_CLK_PIN(sub_pin), .BUS_ACTIVE(bus_act),
		.ADDR_IN(bi[40:21]), .DATA_IN(bi[20:5]), .CS_B_IN(bi[4:1]),
		.BYTE_HIGH_IN(bi[0]), .READ_B_IN(si[5]), .WRITE_LOW_IN(si[4]),
		.WRITE_HIGH_IN(si[3]), .HOLD_ACK_IN(si[2]), .BUS_CLK_IN(si[1]),
		.ALE_IN(si[0]), .MODE(mode), .POWER_STATE(ps), .DIV8_FORCE(div8),
		.MAINOSC_DRIVE_HIGH(drv), .WAKE_ACK(wack), .CPU_CLK_EN(cpu_en),
		.WDT_CLK_EN(wdt_en), .PERIPH_CLK_EN(per_en),
		.CONVERTER_CLK_EN(cnv_en), .SUB_DIV32_CLK_EN(s32), .MAIN_OSC_RUN(mrun),
		.SUB_OSC_RUN(srun), .RING_OSC_RUN(rrun), .ADDR_OUT(ho[40:21]),
		.DATA_OUT(ho[20:5]), .CS_B_OUT(ho[4:1]), .BYTE_HIGH_OUT(ho[0]),
		.READ_B_OUT(so[5]), .WRITE_LOW_OUT(so[4]), .WRITE_HIGH_OUT(so[3]),
		.HOLD_ACK_OUT(so[2]), .BUS_CLK_OUT(so[1]), .ALE_OUT(so[0]),
		.CLOCK_OUT_PIN(cko_pin)
	);

	irq_source_model u_irq_source_model (
		.clk(clk), .rst_b(rst_b), .arm(arm), .pick(pick), .lag(lag),
		.wake_ack(wack), .irq(irq)
	);

	always #5 clk = ~clk;
	always #40 sub_pin = ~sub_pin;

	task automatic ck(input bit ok, input string m);
		n_checks++;
		if (!ok) begin
			failures++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	function automatic int div_of(input logic [9:0] c);
		if (c[5])
			return 8;
		return c[3:2] == 2'h3 ? 16 : 1 << c[3:2];
	endfunction

	function automatic bit wake_ok(input bit stop, input bit g, input int k);
		case (k)
			4: return stop ? qv[0] : !g || qv[0];
			5: return stop ? qv[1] && qv[3] : !g || qv[1] || qv[2];
			6: return !stop && !g && qv[4];
			default: return 1'b1;
		endcase
	endfunction

	// Distance between two CPU ticks, after syncing to one
	task automatic period(output int q);
		repeat (2) begin
			q = 0;
			do begin
				@(negedge clk);
				q++;
			end while (cpu_en !== 1'b1 && q < 64);
		end
	endtask

	task automatic wr(input logic [9:0] c);
		@(negedge clk);
		cf <= c;
		cfg_wr <= 1'b1;
		@(negedge clk);
		cfg_wr <= 1'b0;
	endtask

	// Enter wait or stop, probe pins and clocks, then wake
	task automatic nap(input bit stop, input int p0);
		logic [40:0]       held;
		pmc_pkg::mode_type m0;
		logic              g, last, ro;
		bit                ok;
		int                t, k, q, n;
		held = bi;
		m0 = mode;
		g = cf[8];
		ro = cf[0] || wdt;
		@(negedge clk);
		if (stop) stop_wr <= 1'b1;
		else wait_ex <= 1'b1;
		@(negedge clk);
		stop_wr <= 1'b0;
		wait_ex <= 1'b0;
		bi <= 41'({$random(seed), $random(seed)});
		ck(ps === (stop ? pmc_pkg::PS_STOP : pmc_pkg::PS_WAIT), "entry");
		ck(!stop || div8 === 1'b1 && drv === 1'b1, "stop forcing");
		wr(10'h3ff);
		last = cko_pin;
		t = 0;
		n = 0;
		repeat (20) begin
			@(negedge clk);
			t += int'(cko_pin !== last);
			n += int'(s32 === 1'b1);
			last = cko_pin;
			ck(cpu_en === 1'b0, "cpu gated");
			ck({mrun, srun, rrun} === (stop ? 3'h0 : {2'h3, ro}), "osc");
			ck({per_en, cnv_en} === (stop || g ? 2'h0 : 2'h3), "per");
			ck(stop || wdt_en === wdt, "watchdog");
			ck(!bus_act || ho === held && so[5:1] === 5'h1f, "bus");
			ck(!bus_act || stop || so[0] === 1'b0, "ale");
			ck(bus_act || !stop || (cko[1] ? t == 0 : cko_pin === 1'b1), "clock_out_pin stop");
		end
		ck(bus_act || stop || (t > 0) == !g, "clock_out_pin wait");
		ck(stop ? n == 0 : n > 0, "sub timer clock");
		r = $random(seed);
		k = int'(r[10:8]) % 7;
		ok = wake_ok(stop, g, k);
		repeat (2) begin
			pick <= ps === pmc_pkg::PS_RUN ? 7'h00 : 7'(1 << k);
			lag <= r[14:11];
			arm <= 1'b1;
			@(negedge clk);
			arm <= 1'b0;
			for (q = 0; q < 40 && ps !== pmc_pkg::PS_RUN; q++) @(negedge clk);
			ck((ps === pmc_pkg::PS_RUN) == ok, "wake");
			ok = 1'b1;
			k = 0;
		end
		period(q);
		ck(q == p0, "divide after wake");
		ck(stop || mode === m0, "mode kept");
	endtask

	initial begin
		{clk, rst_b, cfg_wr, stop_wr, wait_ex, wdt, bus_act, sub_pin} = '0;
		{arm, cf, qv, cko, si, lag, pick, bi} = '0;
		failures = 0;
		n_checks = 0;
		seed = 32'ha967;
		repeat (16) @(negedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		ck(mode === pmc_pkg::MODE_MEDIUM && div8 === 1'b1, "reset");
		period(p);
		ck(p == 8, "reset divide");
		for (i = 0; i < 12; i++) begin
			r = $random(seed);
			v = r[9:0] & 10'h1ad;
			v[0] = i[0];
			wr(v);
			em = v[5] || v[3:2] != 2'h0 ? pmc_pkg::MODE_MEDIUM : pmc_pkg::MODE_HIGH;
			em = v[0] ? pmc_pkg::MODE_ONCHIP : em;
			ck(mode === em, "mode decode");
			period(p);
			ck(p == div_of(v), "cpu divide");
		end
		wr(10'h002);
		ck(mode === pmc_pkg::MODE_PLL, "pll mode");
		wr(10'h045);
		ck(mode === pmc_pkg::MODE_ONCHIP_LP, "onchip low power");
		period(p);
		ck(p == 2, "low power divide");
		wr(10'h090);
		ck(mode === pmc_pkg::MODE_LOW, "low speed");
		wr(10'h0d0);
		ck(mode === pmc_pkg::MODE_LOW_POWER && div8 === 1'b1, "main off");
		wr(10'h090);
		for (i = 0; i < 16; i++) begin
			r = $random(seed);
			v = (r[9:0] & 10'h1ad) | 10'h080;
			bus_act <= r[12];
			qv <= r[17:13];
			wdt <= r[18];
			si <= r[24:19];
			cko <= i[0] ? {i[1], !i[1]} : {1'b1, i[1]};
			bi <= 41'({$random(seed), $random(seed)});
			wr(v);
			nap(i[0], i[0] ? 8 : div_of(v));
		end
		give_verdict;
	end

	initial begin
		#400000;
		failures++;
		give_verdict;
	end
endmodule

// file: wake_qualify.sv
// Wake qualification for wait and stop states.
// Assumes peripheral requests arrive only when their priority is nonzero.
`timescale 1ns/10ps

module wake_qualify (
	// State
	input  wire logic in_wait,
	input  wire logic in_stop,
	input  wire logic gate_wait,
	// Sources
	input  wire logic nmi_irq,
	input  wire logic lvd_irq,
	input  wire logic key_irq,
	input  wire logic pin_irq,
	input  wire logic ser_irq,
	input  wire logic ser_ext_clk,
	input  wire logic tmr_irq,
	input  wire logic tmr_event_mode,
	input  wire logic tmr_sub_src,
	input  wire logic tmr_ext_pulse,
	input  wire logic conv_irq,
	input  wire logic conv_single,
	// Result
	output logic      wake
);

	logic always_ok;
	logic wait_ok;
	logic stop_ok;

	assign always_ok = nmi_irq || lvd_irq || key_irq || pin_irq;

	// Gated wait keeps NMI, LVD, key, pin and externally clocked sources
	assign wait_ok = always_ok
		|| (ser_irq && (!gate_wait || ser_ext_clk))             // [RL13]
		|| (conv_irq && conv_single && !gate_wait)              // [RL14]
		|| (tmr_irq && (!gate_wait || tmr_event_mode
			|| tmr_sub_src));                                   // [RL14]

	assign stop_ok = always_ok
		|| (tmr_irq && tmr_event_mode && tmr_ext_pulse)         // [RL19]
		|| (ser_irq && ser_ext_clk);                            // [RL19]

	assign wake = (in_wait && wait_ok) || (in_stop && stop_ok); // [RL11]

endmodule
